// [verilog/aprs_pkg.sv]
// aprs_pkg: register map, field positions, reset values and timing for the axis position logic
package aprs_pkg;
   // ------------------------------------------------------------
   // clock and timing
   // ------------------------------------------------------------
   localparam int unsigned CLK_HZ = 125_000_000; // system clock rate
   localparam int unsigned EDGE_MAX_HZ = 100_000; // fastest phase edge rate
   localparam int unsigned EDGE_MIN_CYC = CLK_HZ / EDGE_MAX_HZ; // cycles between edges, rounded down
   localparam int unsigned MARK_MIN_US = 100; // shortest marker pulse in us
   localparam int unsigned MARK_MIN_CYC = (MARK_MIN_US * (CLK_HZ / 1_000_000)); // least cycles, exact

   // ------------------------------------------------------------
   // register byte offsets
   // ------------------------------------------------------------
   localparam logic [7:0] OFS_CTRL = 8'h00; // control bits
   localparam logic [7:0] OFS_STATUS = 8'h04; // status, read only
   localparam logic [7:0] OFS_POS = 8'h08; // axis position, read only
   localparam logic [7:0] OFS_ZERO = 8'h0C; // zero offset preset
   localparam logic [7:0] OFS_FEED = 8'h10; // search feed
   localparam logic [7:0] OFS_CREEP = 8'h14; // creep speed
   localparam logic [7:0] OFS_LIM_LO = 8'h18; // lower limit position
   localparam logic [7:0] OFS_LIM_HI = 8'h1C; // upper limit position
   localparam logic [7:0] OFS_JOG = 8'h20; // signed jog velocity

   // ------------------------------------------------------------
   // control field positions
   // ------------------------------------------------------------
   localparam int CTRL_MULT_LSB = 0; // two-bit multiplication code
   localparam int CTRL_MARK_NEG = 2; // marker active low when set
   localparam int CTRL_DIR_NEG = 3; // search starts backward when set
   localparam int CTRL_START = 4; // write one starts a search
   localparam int CTRL_ALL_REF = 5; // every other axis is referenced
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000; // x1, positive marker, forward

   // ------------------------------------------------------------
   // multiplication codes and bus responses
   // ------------------------------------------------------------
   localparam logic [1:0] MULT_X1 = 2'h0; // count a rising only
   localparam logic [1:0] MULT_X2 = 2'h1; // count both a edges
   localparam logic [1:0] MULT_X4 = 2'h2; // count every edge
   localparam logic [1:0] RESP_OKAY = 2'h0; // normal answer
   localparam logic [1:0] RESP_SLVERR = 2'h2; // unmapped address

   // search sequence states
   typedef enum logic [2:0] {S_IDLE, S_APPROACH, S_CREEP, S_WAIT_MARK, S_DONE} aprs_state_t;
endpackage : aprs_pkg

// [verilog/aprs_axis.sv]
// aprs_axis: quadrature position counter, marker qualifier and reference search for one axis
`timescale 1ns/1ps
module aprs_axis
   import aprs_pkg::*;
#(
   parameter int unsigned MARK_QUAL_CYC = MARK_MIN_CYC // marker hold before it is taken
) (
   input wire logic aclk, // system clock
   input wire logic aresetn, // synchronous reset, active low
   input wire logic [7:0] s_axi_awaddr, // write address
   input wire logic s_axi_awvalid, // write address valid
   output logic s_axi_awready, // write address ready
   input wire logic [31:0] s_axi_wdata, // write data
   input wire logic [3:0] s_axi_wstrb, // byte enables
   input wire logic s_axi_wvalid, // write data valid
   output logic s_axi_wready, // write data ready
   output logic [1:0] s_axi_bresp, // write response
   output logic s_axi_bvalid, // write response valid
   input wire logic s_axi_bready, // write response ready
   input wire logic [7:0] s_axi_araddr, // read address
   input wire logic s_axi_arvalid, // read address valid
   output logic s_axi_arready, // read address ready
   output logic [31:0] s_axi_rdata, // read data
   output logic [1:0] s_axi_rresp, // read response
   output logic s_axi_rvalid, // read data valid
   input wire logic s_axi_rready, // read data ready
   input wire logic phase_a_input, // transducer phase a
   input wire logic phase_b_input, // transducer phase b
   input wire logic marker_in, // transducer marker pulse
   input wire logic area_closed, // area switch closed, not actuated
   output logic signed [31:0] vel_cmd, // velocity command to the drive
   output logic ref_done, // reference point established
   output logic jog_blocked // jog held back by switch or limit
);
   import aprs_pkg::*;

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   logic [31:0] ctrl_q; // control bits
   logic [31:0] zero_q, feed_q, creep_q; // search settings
   logic signed [31:0] lim_lo_q, lim_hi_q, jog_q; // limits and jog
   logic signed [31:0] pos_q; // axis position
   logic [31:0] bus_rdata_q; // read data
   logic bvalid_q, rvalid_q; // pending answers
   logic [1:0] bresp_q, rresp_q; // answer codes
   aprs_state_t state_q; // search sequence
   logic ref_done_q; // reference established
   logic a_q, b_q; // previous phase levels
   logic [31:0] mark_cnt_q; // marker hold counter
   logic mark_taken_q; // marker already reported
   logic signed [31:0] vel_q; // registered velocity

   // ------------------------------------------------------------
   // bus write side
   // ------------------------------------------------------------
   logic wr_go, rd_go, start_pulse; // handshakes and search start
   // both write channels taken together once no answer is pending
   assign wr_go = s_axi_awvalid & s_axi_wvalid & ~bvalid_q;
   assign s_axi_awready = wr_go;
   assign s_axi_wready = wr_go;
   assign start_pulse = wr_go && s_axi_awaddr == OFS_CTRL && s_axi_wstrb[0] && s_axi_wdata[CTRL_START];

   // byte lane merge of a write into an old word
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            r[8*i +: 8] = nw[8*i +: 8];
         end
      end
      return r;
   endfunction : merge

   // register writes; start bit never stored
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_q <= CTRL_RESET;
         zero_q <= 32'h0000_0000;
         feed_q <= 32'h0000_0000;
         creep_q <= 32'h0000_0000;
         lim_lo_q <= 32'sh0000_0000;
         lim_hi_q <= 32'sh0000_0000;
         jog_q <= 32'sh0000_0000;
      end else if (wr_go) begin
         case (s_axi_awaddr)
            OFS_CTRL: ctrl_q <= merge(ctrl_q, s_axi_wdata, s_axi_wstrb) & ~(32'h1 << CTRL_START);
            OFS_ZERO: zero_q <= merge(zero_q, s_axi_wdata, s_axi_wstrb);
            OFS_FEED: feed_q <= merge(feed_q, s_axi_wdata, s_axi_wstrb);
            OFS_CREEP: creep_q <= merge(creep_q, s_axi_wdata, s_axi_wstrb);
            OFS_LIM_LO: lim_lo_q <= merge(lim_lo_q, s_axi_wdata, s_axi_wstrb);
            OFS_LIM_HI: lim_hi_q <= merge(lim_hi_q, s_axi_wdata, s_axi_wstrb);
            OFS_JOG: jog_q <= merge(jog_q, s_axi_wdata, s_axi_wstrb);
            default: ; // read-only or unmapped: no store
         endcase
      end
   end

   // write response, held until accepted
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_q <= 1'b0;
         bresp_q <= RESP_OKAY;
      end else if (wr_go) begin
         bvalid_q <= 1'b1;
         bresp_q <= (s_axi_awaddr <= OFS_JOG && s_axi_awaddr[1:0] == 2'h0) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
         bvalid_q <= 1'b0;
      end
   end
   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;

   // ------------------------------------------------------------
   // bus read side
   // ------------------------------------------------------------
   assign rd_go = s_axi_arvalid & ~rvalid_q;
   assign s_axi_arready = ~rvalid_q;

   // read mux and response, held until accepted
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_q <= 1'b0;
         rresp_q <= RESP_OKAY;
         bus_rdata_q <= 32'h0000_0000;
      end else if (rd_go) begin
         rvalid_q <= 1'b1;
         rresp_q <= RESP_OKAY;
         case (s_axi_araddr)
            OFS_CTRL: bus_rdata_q <= ctrl_q;
            OFS_STATUS: bus_rdata_q <= {26'h0, jog_blocked, area_closed, ref_done_q, state_q};
            OFS_POS: bus_rdata_q <= pos_q;
            OFS_ZERO: bus_rdata_q <= zero_q;
            OFS_FEED: bus_rdata_q <= feed_q;
            OFS_CREEP: bus_rdata_q <= creep_q;
            OFS_LIM_LO: bus_rdata_q <= lim_lo_q;
            OFS_LIM_HI: bus_rdata_q <= lim_hi_q;
            OFS_JOG: bus_rdata_q <= jog_q;
            default: begin // unmapped
               bus_rdata_q <= 32'h0000_0000;
               rresp_q <= RESP_SLVERR;
            end
         endcase
      end else if (s_axi_rready) begin
         rvalid_q <= 1'b0;
      end
   end
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rdata = bus_rdata_q;
   assign s_axi_rresp = rresp_q;

   // ------------------------------------------------------------
   // quadrature decoder
   // ------------------------------------------------------------
   logic a_edge, b_edge, a_up, b_up, step_en, step_up; // edge events
   logic [1:0] mult; // multiplication code
   assign mult = ctrl_q[CTRL_MULT_LSB +: 2];
   assign a_edge = phase_a_input ^ a_q;
   assign b_edge = phase_b_input ^ b_q;
   assign a_up = phase_a_input ^ phase_b_input;
   assign b_up = ~(phase_a_input ^ phase_b_input);

   // pick which edges count for the chosen factor
   always_comb begin
      step_en = 1'b0;
      step_up = a_up;
      case (mult)
         MULT_X1: step_en = a_edge & phase_a_input;
         MULT_X2: step_en = a_edge;
         MULT_X4: begin
            step_en = a_edge | b_edge;
            step_up = a_edge ? a_up : b_up;
         end
         default: step_en = 1'b0; // reserved code holds the count
      endcase
   end

   // previous phase levels
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         a_q <= 1'b0;
         b_q <= 1'b0;
      end else begin
         a_q <= phase_a_input;
         b_q <= phase_b_input;
      end
   end

   // ------------------------------------------------------------
   // marker qualifier
   // ------------------------------------------------------------
   logic mark_lvl, mark_hit; // polarity-corrected level, taken pulse
   assign mark_lvl = marker_in ^ ctrl_q[CTRL_MARK_NEG];
   assign mark_hit = mark_lvl && !mark_taken_q && mark_cnt_q >= MARK_QUAL_CYC - 1;

   // count hold time, report once per pulse
   always_ff @(posedge aclk) begin
      if (!aresetn || !mark_lvl) begin
         mark_cnt_q <= 32'h0000_0000;
         mark_taken_q <= 1'b0;
      end else begin
         if (mark_cnt_q < MARK_QUAL_CYC) begin
            mark_cnt_q <= mark_cnt_q + 32'h1;
         end
         if (mark_hit) begin
            mark_taken_q <= 1'b1;
         end
      end
   end

   // ------------------------------------------------------------
   // reference search and position
   // ------------------------------------------------------------
   logic preset; // marker during marker wait
   assign preset = state_q == S_WAIT_MARK && mark_hit;

   // search sequence
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_q <= S_IDLE;
         ref_done_q <= 1'b0;
      end else begin
         case (state_q)
            S_IDLE, S_DONE: if (start_pulse) begin
               state_q <= S_APPROACH;
               ref_done_q <= 1'b0;
            end
            S_APPROACH: if (!area_closed) state_q <= S_CREEP;
            S_CREEP: if (area_closed) state_q <= S_WAIT_MARK;
            S_WAIT_MARK: if (mark_hit) begin
               state_q <= S_DONE;
               ref_done_q <= 1'b1;
            end
            default: state_q <= S_IDLE;
         endcase
      end
   end

   // position counter, preset wins over a step
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pos_q <= 32'sh0000_0000;
      end else if (preset) begin
         pos_q <= zero_q;
      end else if (step_en) begin
         pos_q <= step_up ? pos_q + 32'sh1 : pos_q - 32'sh1;
      end
   end

   // ------------------------------------------------------------
   // velocity command and jog guard
   // ------------------------------------------------------------
   logic lim_est, lim_hit, sw_stop; // limit guards
   logic signed [31:0] feed_s, creep_s; // signed search speeds
   assign lim_est = ref_done_q & ctrl_q[CTRL_ALL_REF];
   assign lim_hit = lim_est && ((jog_q > 0 && pos_q >= lim_hi_q) || (jog_q < 0 && pos_q <= lim_lo_q));
   assign sw_stop = !lim_est && !area_closed;
   assign jog_blocked = lim_hit | sw_stop;
   assign feed_s = ctrl_q[CTRL_DIR_NEG] ? -$signed(feed_q) : $signed(feed_q);
   assign creep_s = ctrl_q[CTRL_DIR_NEG] ? $signed(creep_q) : -$signed(creep_q);

   // velocity per phase of the search, jog otherwise
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         vel_q <= 32'sh0000_0000;
      end else begin
         case (state_q)
            S_APPROACH: vel_q <= feed_s;
            S_CREEP, S_WAIT_MARK: vel_q <= creep_s;
            default: vel_q <= jog_blocked ? 32'sh0000_0000 : jog_q;
         endcase
      end
   end
   assign vel_cmd = vel_q;
   assign ref_done = ref_done_q;

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   property p_inc_a_lead;
      @(posedge aclk) disable iff (!aresetn) (mult == MULT_X4 && a_edge && !b_edge && a_up && !preset)
         |=> pos_q == $past(pos_q) + 32'sh1;
   endproperty
   a_inc_a_lead: assert property (p_inc_a_lead) else $error("a lead did not count up");
   property p_x1_ignores_b;
      @(posedge aclk) disable iff (!aresetn) (mult == MULT_X1 && !a_edge && b_edge && !preset)
         |=> $stable(pos_q);
   endproperty
   a_x1_ignores_b: assert property (p_x1_ignores_b) else $error("x1 counted a b edge");
   property p_x4_b_step;
      @(posedge aclk) disable iff (!aresetn) (mult == MULT_X4 && b_edge && !a_edge && !b_up && !preset)
         |=> pos_q == $past(pos_q) - 32'sh1;
   endproperty
   a_x4_b_step: assert property (p_x4_b_step) else $error("x4 missed a b edge");
   property p_start_approach;
      @(posedge aclk) disable iff (!aresetn) (state_q == S_IDLE && start_pulse)
         |=> state_q == S_APPROACH ##1 vel_cmd == feed_s;
   endproperty
   a_start_approach: assert property (p_start_approach) else $error("search did not start at feed");
   property p_reverse;
      @(posedge aclk) disable iff (!aresetn) (state_q == S_APPROACH && !area_closed)
         |=> state_q == S_CREEP ##1 vel_cmd == creep_s;
   endproperty
   a_reverse: assert property (p_reverse) else $error("no reversal at creep");
   property p_preset;
      @(posedge aclk) disable iff (!aresetn) preset |=> pos_q == $past(zero_q) && ref_done_q;
   endproperty
   a_preset: assert property (p_preset) else $error("marker did not preset position");
   property p_mark_hold;
      @(posedge aclk) disable iff (!aresetn) mark_hit |-> $past(mark_lvl, 1) || MARK_QUAL_CYC <= 1;
   endproperty
   a_mark_hold: assert property (p_mark_hold) else $error("marker taken too early");
   property p_limit;
      @(posedge aclk) disable iff (!aresetn)
         ((state_q == S_IDLE || state_q == S_DONE) && lim_est && jog_q > 0 && pos_q >= lim_hi_q)
         |=> vel_cmd == 32'sh0000_0000;
   endproperty
   a_limit: assert property (p_limit) else $error("jog passed upper limit");
   property p_sw_stop;
      @(posedge aclk) disable iff (!aresetn) (state_q == S_IDLE && !lim_est && !area_closed)
         |=> vel_cmd == 32'sh0000_0000;
   endproperty
   a_sw_stop: assert property (p_sw_stop) else $error("jog ran on actuated switch");
endmodule : aprs_axis

// [tb/aprs_xdcr_model.sv]
// aprs_xdcr_model: behavioural rotary transducer with marker and area switch cam
`timescale 1ns/1ps
module aprs_xdcr_model
   import aprs_pkg::*;
#(
   parameter int GAP = EDGE_MIN_CYC, // cycles between phase edges
   parameter int CAM_POS = 8, // edge count where the cam opens the switch
   parameter int MARK_POS = 60, // marker angle in edges, 64 edges a turn
   parameter int MARK_LEN = MARK_MIN_CYC // marker pulse length in cycles
) (
   input wire logic aclk, // system clock
   input wire logic aresetn, // synchronous reset, active low
   input wire logic signed [31:0] vel_cmd, // drive command from the axis
   input wire logic [1:0] mode, // 0 follow drive, 1 up, 2 down, 3 hold
   input wire logic mark_neg, // marker idles high when set
   output logic phase_a_input, // phase a
   output logic phase_b_input, // phase b
   output logic marker_in, // marker pulse
   output logic area_closed // switch closed, not actuated
);
   // ------------------------------------------------------------
   // shaft motion
   // ------------------------------------------------------------
   int pos_q; // shaft position in edges
   int pos_d; // position after the next edge
   int gap_q; // cycles since the last edge
   int mark_q; // marker cycles still to run
   logic up; // moving forward
   logic dn; // moving backward
   logic fire; // an edge happens at this clock
   assign up = (mode == 2'h1) || (mode == 2'h0 && vel_cmd > 0);
   assign dn = (mode == 2'h2) || (mode == 2'h0 && vel_cmd < 0);
   assign fire = (gap_q >= GAP - 1) && (up || dn);
   assign pos_d = up ? pos_q + 1 : pos_q - 1;
   // never faster than one edge per GAP cycles
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pos_q <= 0;
         gap_q <= 0;
      end else if (fire) begin
         pos_q <= pos_d;
         gap_q <= 0;
      end else if (gap_q < GAP - 1) begin
         gap_q <= gap_q + 1;
      end
   end
   // one marker a turn (or a linear pitch) at a fixed place, held for the full pulse length
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mark_q <= 0;
      end else if (fire && pos_d[5:0] == 6'(MARK_POS)) begin
         mark_q <= MARK_LEN;
      end else if (mark_q > 0) begin
         mark_q <= mark_q - 1;
      end
   end
   // ideal quadrature, no edge jitter; a leads when moving up
   assign phase_a_input = pos_q[1] ^ pos_q[0];
   assign phase_b_input = pos_q[1];
   assign marker_in = (mark_q > 0) ^ mark_neg;
   assign area_closed = pos_q < CAM_POS; // cam opens the switch at the far end
endmodule : aprs_xdcr_model

// [tb/aprs_axis_tb_top.sv]
// aprs_axis_tb_top: register-driven bench for one axis with transducer model
`timescale 1ns/1ps
module aprs_axis_tb_top;
   import aprs_pkg::*;
   // ------------------------------------------------------------
   // signals
   // ------------------------------------------------------------
   logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, pa, pb, mk, area_closed, ref_done, jog_blocked;
   logic [7:0] s_axi_awaddr, s_axi_araddr; // bus addresses
   logic [31:0] s_axi_wdata, s_axi_rdata, exp_pos; // bus data, expected position
   logic [3:0] s_axi_wstrb; // byte enables
   logic [1:0] s_axi_bresp, s_axi_rresp, mode; // responses, model motion mode
   logic signed [31:0] vel_cmd; // drive command
   int n_mismatch, comparisons; // error and compare counters
   logic [1:0] codes [4] = '{MULT_X1, MULT_X2, 2'h3, MULT_X4}; // multiplication codes
   int per4 [4] = '{1, 2, 0, 4}; // counts per four edges for each code
   aprs_axis #(.MARK_QUAL_CYC(4)) DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready), .phase_a_input(pa), .phase_b_input(pb), .marker_in(mk),
      .area_closed(area_closed), .vel_cmd(vel_cmd), .ref_done(ref_done), .jog_blocked(jog_blocked));
   aprs_xdcr_model xdcr (.aclk(aclk), .aresetn(aresetn), .vel_cmd(vel_cmd), .mode(mode), .mark_neg(1'b0),
      .phase_a_input(pa), .phase_b_input(pb), .marker_in(mk), .area_closed(area_closed));
   // 125 MHz clock
   initial begin
      aclk = 1'b0;
      forever #4 aclk = ~aclk;
   end
   // ------------------------------------------------------------
   // tasks
   // ------------------------------------------------------------
   task automatic print_verdict();
      $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
      if (n_mismatch == 0 && comparisons > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : print_verdict
   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      comparisons++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("BAD t=%0t %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask : check
   // bounded wait for a level, sampled at each rising edge
   task automatic wait_for(input int sel, input logic lvl);
      int n;
      logic v;
      n = 0;
      do begin
         @(posedge aclk);
         n++;
         case (sel)
            0: v = area_closed;
            1: v = ref_done;
            2: v = s_axi_awready & s_axi_wready;
            3: v = s_axi_bvalid;
            4: v = s_axi_arready;
            default: v = s_axi_rvalid;
         endcase
      end while (v !== lvl && n < 30000);
      if (v !== lvl) begin
         n_mismatch++;
         $display("BAD t=%0t wait timed out", $time);
         print_verdict();
      end
   endtask : wait_for
   task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      wait_for(2, 1'b1);
      s_axi_awvalid <= 1'b0;
      s_axi_wvalid <= 1'b0;
      s_axi_bready <= 1'b1;
      wait_for(3, 1'b1);
      s_axi_bready <= 1'b0;
      check({30'h0, s_axi_bresp}, {30'h0, er}, "bresp");
   endtask : axi_write
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      wait_for(4, 1'b1);
      s_axi_arvalid <= 1'b0;
      s_axi_rready <= 1'b1;
      wait_for(5, 1'b1);
      s_axi_rready <= 1'b0;
      check(s_axi_rdata, e, "rdata");
      check({30'h0, s_axi_rresp}, {30'h0, er}, "rresp");
   endtask : rd_chk
   // shaft moves ne edges in the given mode, then stands
   task automatic move(input logic [1:0] m, input int ne);
      mode <= m;
      repeat (ne * EDGE_MIN_CYC) @(posedge aclk);
      mode <= 2'h3;
   endtask : move
   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      int ne;
      n_mismatch = 0;
      comparisons = 0;
      aresetn = 1'b0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
      s_axi_awaddr = 8'h00;
      s_axi_araddr = 8'h00;
      s_axi_wdata = 32'h0000_0000;
      s_axi_wstrb = 4'hF;
      mode = 2'h3;
      exp_pos = 32'h0000_0000;
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      rd_chk(OFS_CTRL, CTRL_RESET, RESP_OKAY);
      rd_chk(OFS_STATUS, 32'h0000_0010, RESP_OKAY);
      axi_write(8'h40, 32'h0000_0001, RESP_SLVERR);
      rd_chk(8'h40, 32'h0000_0000, RESP_SLVERR);
      // every multiplication code, both directions
      for (int i = 0; i < 4; i++) begin
         ne = (i == 3) ? 8 : 4;
         axi_write(OFS_CTRL, {30'h0, codes[i]}, RESP_OKAY);
         move(2'h1, ne);
         exp_pos = exp_pos + 32'(per4[i] * ne / 4);
         rd_chk(OFS_POS, exp_pos, RESP_OKAY);
         if (i == 3) begin
            axi_write(OFS_JOG, 32'h0000_0005, RESP_OKAY);
            repeat (2) @(posedge aclk);
            check(vel_cmd, 32'h0000_0000, "jog into cam");
            check({31'h0, jog_blocked}, 32'h0000_0001, "jog held");
            axi_write(OFS_JOG, 32'h0000_0000, RESP_OKAY);
         end
         move(2'h2, ne);
         exp_pos = exp_pos - 32'(per4[i] * ne / 4);
         rd_chk(OFS_POS, exp_pos, RESP_OKAY);
      end
      // full reference search, forward start
      axi_write(OFS_ZERO, 32'h0000_0123, RESP_OKAY);
      axi_write(OFS_FEED, 32'h0000_0064, RESP_OKAY);
      axi_write(OFS_CREEP, 32'h0000_0007, RESP_OKAY);
      mode <= 2'h0;
      axi_write(OFS_CTRL, 32'h0000_0012, RESP_OKAY);
      repeat (3) @(posedge aclk);
      check(vel_cmd, 32'h0000_0064, "search feed");
      wait_for(0, 1'b0);
      repeat (3) @(posedge aclk);
      check(vel_cmd, 32'hFFFF_FFF9, "creep reversed");
      wait_for(0, 1'b1);
      check(vel_cmd, 32'hFFFF_FFF9, "creep until closed");
      check({31'h0, ref_done}, 32'h0000_0000, "no preset yet");
      wait_for(1, 1'b1);
      repeat (2) @(posedge aclk);
      rd_chk(OFS_POS, 32'h0000_0123, RESP_OKAY);
      rd_chk(OFS_STATUS, 32'h0000_001C, RESP_OKAY);
      // soft limit only with every axis referenced
      mode <= 2'h3;
      axi_write(OFS_LIM_HI, 32'h0000_0123, RESP_OKAY);
      axi_write(OFS_CTRL, 32'h0000_0022, RESP_OKAY);
      axi_write(OFS_JOG, 32'h0000_0005, RESP_OKAY);
      repeat (2) @(posedge aclk);
      check({31'h0, jog_blocked}, 32'h0000_0001, "limit holds jog");
      check(vel_cmd, 32'h0000_0000, "limit stops drive");
      axi_write(OFS_CTRL, 32'h0000_0002, RESP_OKAY);
      repeat (2) @(posedge aclk);
      check({31'h0, jog_blocked}, 32'h0000_0000, "limit inactive");
      check(vel_cmd, 32'h0000_0005, "jog passes");
      // lower limit holds a backward jog once every axis is referenced
      axi_write(OFS_LIM_LO, 32'h0000_0200, RESP_OKAY);
      axi_write(OFS_JOG, 32'hFFFF_FFFB, RESP_OKAY);
      axi_write(OFS_CTRL, 32'h0000_0022, RESP_OKAY);
      repeat (2) @(posedge aclk);
      check({31'h0, jog_blocked}, 32'h0000_0001, "lower limit holds jog");
      check(vel_cmd, 32'h0000_0000, "lower limit stops drive");
      axi_write(OFS_JOG, 32'h0000_0000, RESP_OKAY);
      // backward start of a second search
      axi_write(OFS_CTRL, 32'h0000_001A, RESP_OKAY);
      repeat (3) @(posedge aclk);
      check(vel_cmd, 32'hFFFF_FF9C, "backward feed");
      print_verdict();
   end
endmodule : aprs_axis_tb_top
